// *** sar_pkg.sv ***
package sar_pkg;
    // Result width and straight binary code range.
    localparam int RES_BITS = 16;
    localparam logic [RES_BITS-1:0] RES_ZERO = 16'h0000;

    // System clock period and conversion time window in ns.
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_CONV_MIN_NS = 500;
    localparam int T_CONV_MAX_NS = 1300;

    // The least time rounds up and the longest rounds down to whole cycles.
    localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 10;

    // Falling serial clock edges in one frame, with and without the busy bit.
    localparam int FRAME_PLAIN = 16;
    localparam int FRAME_BUSY = 17;
    localparam int FALL_CNT_W = 5;

    // Result buffer depth.
    localparam int FIFO_DEPTH = 32;

    // Readout sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONV,
        ST_LOAD,
        ST_ACQ,
        ST_SHIFT
    } sar_state_t;
endpackage

// *** sar_fifo_if.sv ***
`timescale 1ns/1ps
interface sar_fifo_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] wData;
    logic wValid;
    logic wReady;
    logic [WIDTH-1:0] rData;
    logic rValid;
    logic rReady;

    modport producer (output wData, output wValid, input wReady,
                      input rData, input rValid, output rReady);
    modport buffer (input wData, input wValid, output wReady,
                    output rData, output rValid, input rReady);
endinterface

// *** sar_fifo.sv ***
`timescale 1ns/1ps
module sar_fifo
    import sar_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    sar_fifo_if.buffer fb
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [WIDTH-1:0] head_q;
    logic headValid_q;
    wire doWrite;
    wire memHasData;
    wire doFetch;

    // Full and empty come straight from the occupancy count.
    assign fb.wReady = (count_q != (AW+1)'(DEPTH));
    assign doWrite = fb.wValid && fb.wReady;
    assign memHasData = (count_q != '0);
    assign doFetch = memHasData && (!headValid_q || fb.rReady);
    assign fb.rData = head_q;
    assign fb.rValid = headValid_q;

    // Storage array has no reset so it maps onto plain memory.
    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr_q] <= fb.wData;
        end
    end

    // Pointers, count and a registered head word for the reader.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            head_q <= '0;
            headValid_q <= 1'b0;
        end else begin
            if (doWrite) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doFetch) begin
                rdPtr_q <= rdPtr_q + 1'b1;
                head_q <= mem[rdPtr_q];
            end
            count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doFetch);
            if (doFetch) begin
                headValid_q <= 1'b1;
            end else if (fb.rReady) begin
                headValid_q <= 1'b0;
            end
        end
    end
endmodule

// *** sar_readout_top.sv ***
`timescale 1ns/1ps
// Function
// - Select level at strobe rise picks mode.
// - Optional busy bit precedes result bits.
// - Internal clock times conversion; serial clock reads.
// - Conversion length stays within minimum and maximum.
// - Conversion end: acquire, power down, result ready.
// - Result is unsigned straight binary, 16 bits.
// - Strobe rise floats output, samples, starts conversion.
// - Started conversion ignores later strobe activity.
// - Strobe high at end: no busy bit, float.
// - Strobe fall after conversion drives MSB out.
// - Later bits follow on serial clock falls.
// - No busy: float after 16th fall or rise.
// - Strobe low at end: drive low busy bit.
// - After busy bit, MSB first per fall.
// - Busy: float after 17th fall or rise.
module sar_readout_top
    import sar_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic conversion_strobe,
    input wire logic selectIn,
    input wire logic serialClk,
    input wire logic [RES_BITS-1:0] coreResult,
    input wire logic coreReady,
    output logic serialOut,
    output logic serialOutEn_n,
    output logic sampleHold,
    output logic powerDown,
    output logic convBusy,
    output logic chainMode
);
    sar_state_t state_q;
    sar_state_t state_d;

    // Two-flop synchronisers; the first stage feeds no logic.
    logic strbMeta_q;
    logic strbSync_q;
    logic strbLast_q;
    logic selMeta_q;
    logic selSync_q;
    logic sclkMeta_q;
    logic sclkSync_q;
    logic sclkLast_q;

    logic [CONV_CNT_W-1:0] convCnt_q;
    logic [RES_BITS-1:0] shift_q;
    logic [FALL_CNT_W-1:0] fallCnt_q;
    logic busyMode_q;
    logic serialOut_q;
    logic outEnN_q;
    logic sampleHold_q;
    logic powerDown_q;
    logic convBusy_q;
    logic chainMode_q;
    logic pushValid_q;
    logic [RES_BITS-1:0] pushData_q;

    wire strbRise;
    wire strbFall;
    wire sclkFall;
    wire convMinMet;
    wire convMaxHit;
    wire convDone;
    wire startOk;
    wire [FALL_CNT_W-1:0] frameLimit;
    wire lastFall;
    wire loadNow;

    sar_fifo_if #(.WIDTH(RES_BITS)) fifoBus ();

    sar_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(DEPTH)
    ) u_sar_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .fb(fifoBus.buffer)
    );

    // Compares the conversion counter against a cycle figure.
    function automatic logic cntReached(input logic [CONV_CNT_W-1:0] cnt, input int cyc);
        cntReached = (cnt >= CONV_CNT_W'(cyc - 1));
    endfunction

    // Pin inputs cross into the system clock domain here.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strbMeta_q <= 1'b0;
            strbSync_q <= 1'b0;
            strbLast_q <= 1'b0;
            selMeta_q <= 1'b0;
            selSync_q <= 1'b0;
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkLast_q <= 1'b0;
        end else begin
            strbMeta_q <= conversion_strobe;
            strbSync_q <= strbMeta_q;
            strbLast_q <= strbSync_q;
            selMeta_q <= selectIn;
            selSync_q <= selMeta_q;
            sclkMeta_q <= serialClk;
            sclkSync_q <= sclkMeta_q;
            sclkLast_q <= sclkSync_q;
        end
    end

    // Edge detection on the synchronised copies only.
    assign strbRise = strbSync_q && !strbLast_q;
    assign strbFall = !strbSync_q && strbLast_q;
    assign sclkFall = !sclkSync_q && sclkLast_q;

    // The core may finish once the minimum has passed; the maximum forces the end.
    assign convMinMet = cntReached(convCnt_q, CONV_MIN_CYC);
    assign convMaxHit = cntReached(convCnt_q, CONV_MAX_CYC);
    assign convDone = (state_q == ST_CONV) && ((convMinMet && coreReady) || convMaxHit);

    // A new conversion is refused while converting, loading or with a full buffer.
    assign startOk = strbRise && fifoBus.wReady
        && (state_q == ST_IDLE || state_q == ST_ACQ || state_q == ST_SHIFT);
    assign frameLimit = busyMode_q ? FALL_CNT_W'(FRAME_BUSY) : FALL_CNT_W'(FRAME_PLAIN);
    assign lastFall = (fallCnt_q == frameLimit - 1'b1);
    assign loadNow = (state_q == ST_LOAD) && fifoBus.rValid;

    // Finished results pass through the buffer towards the shift register.
    assign fifoBus.wData = pushData_q;
    assign fifoBus.wValid = pushValid_q;
    assign fifoBus.rReady = loadNow;

    // Next-state logic of the readout sequencer.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (startOk) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (convDone) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (loadNow) begin
                    if (chainMode_q) begin
                        state_d = ST_IDLE;
                    end else if (busyMode_q) begin
                        state_d = ST_SHIFT;
                    end else begin
                        state_d = ST_ACQ;
                    end
                end
            end
            ST_ACQ: begin
                if (startOk) begin
                    state_d = ST_CONV;
                end else if (strbFall) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (startOk) begin
                    state_d = ST_CONV;
                end else if (strbRise || (sclkFall && lastFall)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state and conversion timing on the internal clock.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            convCnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (startOk) begin
                convCnt_q <= '0;
            end else if (state_q == ST_CONV) begin
                convCnt_q <= convCnt_q + 1'b1;
            end
        end
    end

    // Mode capture at the strobe rise and busy choice at conversion end.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chainMode_q <= 1'b0;
            busyMode_q <= 1'b0;
        end else begin
            if (startOk) begin
                chainMode_q <= !selSync_q;
            end
            if (convDone) begin
                busyMode_q <= !strbSync_q;
            end
        end
    end

    // The core word is straight binary already and is passed on untouched.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pushValid_q <= 1'b0;
            pushData_q <= RES_ZERO;
        end else begin
            pushValid_q <= convDone;
            if (convDone) begin
                pushData_q <= coreResult;
            end
        end
    end

    // Sampling pulse and converter power state; busy has its own flop so the pin is glitch free.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sampleHold_q <= 1'b0;
            powerDown_q <= 1'b1;
            convBusy_q <= 1'b0;
        end else begin
            sampleHold_q <= startOk;
            if (startOk) begin
                powerDown_q <= 1'b0;
                convBusy_q <= 1'b1;
            end else if (convDone) begin
                powerDown_q <= 1'b1;
                convBusy_q <= 1'b0;
            end
        end
    end

    // Output shift register; every result bit on the pin leaves from its top.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shift_q <= RES_ZERO;
            fallCnt_q <= '0;
        end else if (loadNow) begin
            shift_q <= fifoBus.rData;
            fallCnt_q <= '0;
        end else if (state_q == ST_ACQ && strbFall) begin
            shift_q <= {shift_q[RES_BITS-2:0], 1'b0};
            fallCnt_q <= '0;
        end else if (state_q == ST_SHIFT && sclkFall) begin
            shift_q <= {shift_q[RES_BITS-2:0], 1'b0};
            fallCnt_q <= fallCnt_q + 1'b1;
        end
    end

    // Pin driver. Float on strobe rise has top priority so a new frame can never collide.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serialOut_q <= 1'b0;
            outEnN_q <= 1'b1;
        end else if (strbRise) begin
            outEnN_q <= 1'b1;
        end else if (loadNow && !chainMode_q && busyMode_q) begin
            serialOut_q <= 1'b0;
            outEnN_q <= 1'b0;
        end else if (state_q == ST_ACQ && strbFall) begin
            serialOut_q <= shift_q[RES_BITS-1];
            outEnN_q <= 1'b0;
        end else if (state_q == ST_SHIFT && sclkFall) begin
            if (lastFall) begin
                outEnN_q <= 1'b1;
            end else begin
                serialOut_q <= shift_q[RES_BITS-1];
            end
        end
    end

    assign serialOut = serialOut_q;
    assign serialOutEn_n = outEnN_q;
    assign sampleHold = sampleHold_q;
    assign powerDown = powerDown_q;
    assign convBusy = convBusy_q;
    assign chainMode = chainMode_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_busy_lead;
        !outEnN_q && !serialOut_q;
    endsequence

    sequence s_loaded;
        fifoBus.rValid && fifoBus.rReady;
    endsequence

    property p_mode_capture;
        startOk |=> chainMode_q == !$past(selSync_q);
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("mode not taken from select");

    property p_conv_window;
        convDone |-> convCnt_q >= CONV_CNT_W'(CONV_MIN_CYC - 1)
            && convCnt_q <= CONV_CNT_W'(CONV_MAX_CYC - 1);
    endproperty
    a_conv_window: assert property (p_conv_window) else $error("conversion length out of window");

    property p_conv_runs;
        state_q == ST_CONV && !convMinMet |=> state_q == ST_CONV;
    endproperty
    a_conv_runs: assert property (p_conv_runs) else $error("conversion cut short");

    property p_rise_floats;
        strbRise |=> outEnN_q && (sampleHold_q == $past(startOk));
    endproperty
    a_rise_floats: assert property (p_rise_floats) else $error("output not floated on strobe rise");

    property p_power_down;
        convDone |=> powerDown_q && pushValid_q;
    endproperty
    a_power_down: assert property (p_power_down) else $error("no power down at conversion end");

    property p_busy_bit;
        convDone && !strbSync_q && !chainMode_q ##1 !strbRise [*3] |-> ##[0:3] s_busy_lead;
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit missing");

    property p_no_busy;
        convDone && strbSync_q |=> outEnN_q;
    endproperty
    a_no_busy: assert property (p_no_busy) else $error("output driven without busy mode");

    property p_load_shift;
        s_loaded |=> shift_q == $past(fifoBus.rData);
    endproperty
    a_load_shift: assert property (p_load_shift) else $error("shift register not loaded");

    property p_msb_out;
        state_q == ST_ACQ && strbFall && !strbRise
            |=> !outEnN_q && serialOut_q == $past(shift_q[RES_BITS-1]);
    endproperty
    a_msb_out: assert property (p_msb_out) else $error("MSB not presented on strobe fall");

    property p_end_plain;
        state_q == ST_SHIFT && sclkFall && !busyMode_q
            && fallCnt_q == FALL_CNT_W'(FRAME_PLAIN - 1) |=> outEnN_q;
    endproperty
    a_end_plain: assert property (p_end_plain) else $error("output not floated after 16 falls");

    property p_end_busy;
        state_q == ST_SHIFT && sclkFall && busyMode_q
            && fallCnt_q == FALL_CNT_W'(FRAME_BUSY - 1) |=> outEnN_q;
    endproperty
    a_end_busy: assert property (p_end_busy) else $error("output not floated after 17 falls");
endmodule

// *** sar_host_model.sv ***
`timescale 1ns/1ps
// Host end of the 4-wire link: strobe, select and serial clock out, pulled-up pin in.
module sar_host_model (
    input wire logic clk_sys,
    input wire logic pinLevel,
    output logic conversion_strobe,
    output logic selectIn,
    output logic serialClk
);
    // The serial clock stands low outside frames so no stray edge reaches the device.
    initial begin
        conversion_strobe = 1'b0;
        selectIn = 1'b1;
        serialClk = 1'b0;
    end

    // The strobe is parked low first, so every call makes a clean rising edge.
    task automatic strobeRise(input logic sel);
        @(negedge clk_sys);
        conversion_strobe <= 1'b0;
        selectIn <= sel;
        repeat (4) @(negedge clk_sys);
        conversion_strobe <= 1'b1;
    endtask

    task automatic strobeFall();
        @(negedge clk_sys);
        conversion_strobe <= 1'b0;
    endtask

    // Bits are taken on the rising serial edge, well away from the hold window after a fall.
    task automatic clockBits(input int n, output logic [16:0] bits);
        bits = '0;
        for (int i = 0; i < n; i++) begin
            #62.5 serialClk = 1'b1;
            bits = {bits[15:0], pinLevel};
            #62.5 serialClk = 1'b0;
        end
        repeat (8) @(negedge clk_sys);
    endtask

    // A falling pin is the ready notice; the wait is bounded so a silent device cannot hang us.
    task automatic waitNotice(output bit seen);
        seen = 1'b0;
        for (int i = 0; i < 400 && !seen; i++) begin
            @(negedge clk_sys);
            seen = (pinLevel === 1'b0);
        end
    endtask
endmodule

// *** sar_readout_top_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(act, exp) begin nCompared++; if ((act) !== (exp)) begin errorCnt++; $display("[ERR] t=%0t act=%0h exp=%0h", $time, (act), (exp)); end end

module sar_readout_top_tb_top;
    import sar_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [RES_BITS-1:0] coreResult = RES_ZERO;
    logic coreReady = 1'b1;
    logic conversion_strobe;
    logic selectIn;
    logic serialClk;
    logic serialOut;
    logic serialOutEn_n;
    logic sampleHold;
    logic powerDown;
    logic convBusy;
    logic chainMode;
    int errorCnt = 0;
    int nCompared = 0;
    int cyc = 0;
    int shCnt = 0;
    int convCyc = 0;
    int lastConv = 0;

    // The data pin has a pull-up, so a floating output reads high.
    wire pinLevel = serialOutEn_n ? 1'b1 : serialOut;

    always #2 clk_sys = ~clk_sys;

    sar_readout_top #(.DEPTH(FIFO_DEPTH)) u_sar_readout_top (.clk_sys(clk_sys), .rst(rst),
        .conversion_strobe(conversion_strobe), .selectIn(selectIn), .serialClk(serialClk),
        .coreResult(coreResult), .coreReady(coreReady), .serialOut(serialOut),
        .serialOutEn_n(serialOutEn_n), .sampleHold(sampleHold), .powerDown(powerDown),
        .convBusy(convBusy), .chainMode(chainMode));
    sar_host_model u_sar_host_model (.clk_sys(clk_sys), .pinLevel(pinLevel),
        .conversion_strobe(conversion_strobe), .selectIn(selectIn), .serialClk(serialClk));

    task automatic endSim();
        $display("compared=%0d errors=%0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Counts sample pulses and conversion length; a hang is cut short well past the planned run.
    always @(posedge clk_sys) begin
        cyc++;
        if (sampleHold === 1'b1) shCnt++;
        if (powerDown === 1'b0) convCyc++;
        else if (convCyc != 0) begin
            lastConv = convCyc;
            convCyc = 0;
        end
        if (cyc == 40000) begin
            errorCnt++;
            endSim();
        end
    end

    task automatic waitConvEnd();
        int k;
        k = 0;
        repeat (6) @(negedge clk_sys);
        while (powerDown !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        `CHK(powerDown, 1'b1)
        `CHK(convBusy, 1'b0)
    endtask

    // Plain conversion with a strobe dip mid-way, held high past the longest time, then selected.
    task automatic plainPrep(input logic [15:0] val, input logic rdy);
        int sh0;
        @(negedge clk_sys);
        coreResult = val;
        coreReady = rdy;
        sh0 = shCnt;
        u_sar_host_model.strobeRise(1'b1);
        repeat (30) @(negedge clk_sys);
        u_sar_host_model.strobeFall();
        repeat (10) @(negedge clk_sys);
        u_sar_host_model.strobeRise(1'b1);
        `CHK(serialOutEn_n, 1'b1)
        waitConvEnd();
        `CHK(shCnt - sh0, 1)
        `CHK(chainMode, 1'b0)
        `CHK(lastConv >= CONV_MIN_CYC - 1 && lastConv <= CONV_MAX_CYC + 1, 1'b1)
        if (!rdy) `CHK(lastConv >= CONV_MAX_CYC - 1, 1'b1)
        repeat (CONV_MAX_CYC - lastConv + 10) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b1)
        u_sar_host_model.strobeFall();
        repeat (8) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b0)
        `CHK(serialOut, val[15])
    endtask

    task automatic tPlain(input logic [15:0] val, input logic rdy);
        logic [16:0] bits;
        plainPrep(val, rdy);
        u_sar_host_model.clockBits(15, bits);
        `CHK(bits[14:0], val[15:1])
        `CHK(serialOutEn_n, 1'b0)
        `CHK(serialOut, val[0])
        u_sar_host_model.clockBits(1, bits);
        `CHK(serialOutEn_n, 1'b1)
    endtask

    // Busy mode: strobe dropped early and held low, so the low busy bit leads the word.
    task automatic tBusy(input logic [15:0] val);
        logic [16:0] bits;
        bit seen;
        @(negedge clk_sys);
        coreResult = val;
        coreReady = 1'b1;
        u_sar_host_model.strobeRise(1'b1);
        repeat (20) @(negedge clk_sys);
        u_sar_host_model.strobeFall();
        u_sar_host_model.waitNotice(seen);
        `CHK(seen, 1'b1)
        `CHK(powerDown, 1'b1)
        u_sar_host_model.clockBits(16, bits);
        `CHK(bits[15:0], {1'b0, val[15:1]})
        `CHK(serialOutEn_n, 1'b0)
        `CHK(serialOut, val[0])
        u_sar_host_model.clockBits(1, bits);
        `CHK(serialOutEn_n, 1'b1)
    endtask

    // A strobe rise in mid-frame floats the pin at once and starts the next conversion.
    task automatic tAbort(input logic [15:0] val);
        logic [16:0] bits;
        int sh0;
        plainPrep(val, 1'b1);
        u_sar_host_model.clockBits(5, bits);
        `CHK(bits[4:0], val[15:11])
        sh0 = shCnt;
        u_sar_host_model.strobeRise(1'b1);
        repeat (6) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b1)
        `CHK(shCnt - sh0, 1)
        `CHK(powerDown, 1'b0)
        waitConvEnd();
        `CHK(serialOutEn_n, 1'b1)
    endtask

    // Select low at the rise picks the chain mode, where this block never drives the pin.
    task automatic tChain();
        u_sar_host_model.strobeRise(1'b0);
        repeat (6) @(negedge clk_sys);
        `CHK(chainMode, 1'b1)
        waitConvEnd();
        u_sar_host_model.strobeFall();
        repeat (8) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b1)
    endtask

    // Two words pass the result buffer in a row; the second must not repeat the first.
    task automatic tFifo(input logic [15:0] v1, input logic [15:0] v2);
        logic [16:0] bits;
        int sh0;
        plainPrep(v1, 1'b1);
        @(negedge clk_sys);
        coreResult = v2;
        sh0 = shCnt;
        u_sar_host_model.strobeRise(1'b1);
        repeat (6) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b1)
        `CHK(convBusy, 1'b1)
        `CHK(shCnt - sh0, 1)
        waitConvEnd();
        repeat (CONV_MAX_CYC - CONV_MIN_CYC + 10) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b1)
        u_sar_host_model.strobeFall();
        repeat (8) @(negedge clk_sys);
        `CHK(serialOutEn_n, 1'b0)
        `CHK(serialOut, v2[15])
        u_sar_host_model.clockBits(15, bits);
        `CHK(bits[14:0], v2[15:1])
        `CHK(serialOut, v2[0])
        u_sar_host_model.clockBits(1, bits);
        `CHK(serialOutEn_n, 1'b1)
    endtask

    // Reset is held for eight cycles, then each scenario runs in turn.
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        tPlain(16'ha5c3, 1'b1);
        tPlain(16'hffff, 1'b0);
        tBusy(16'h0000);
        tBusy(16'h8001);
        tAbort(16'h1234);
        tChain();
        tPlain(16'h0001, 1'b1);
        tFifo(16'h4b2d, 16'hc3e1);
        endSim();
    end
endmodule
